// *** i2csl_defines.svh ***
// constants for the slave-side serial port engine
`ifndef I2CSL_DEFINES_SVH
`define I2CSL_DEFINES_SVH

`define I2CSL_MODE_SLV7      4'h6
`define I2CSL_MODE_SLV10     4'h7
`define I2CSL_MODE_SLV7_SP   4'he
`define I2CSL_MODE_SLV10_SP  4'hf
`define I2CSL_MODE_MASTER    4'h8
`define I2CSL_MODE_FW_MASTER 4'hb
`define I2CSL_MODE_TEN_BIT   0
`define I2CSL_TEN_HDR        5'h1e
`define I2CSL_BITS_PER_BYTE  4'h8
`define I2CSL_LAST_DATA_FALL 4'h7
`define I2CSL_CFG_W          29
`define I2CSL_BYTE_RST       8'h00

`endif

// *** i2csl_pkg.sv ***
// types shared by the slave-side serial port engine
package i2csl_pkg;

    // gray along idle, addr, addr2, rx, tx
    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_addr  = 3'b001,
        st_addr2 = 3'b011,
        st_rx    = 3'b010,
        st_tx    = 3'b110
    } i2csl_state_t;

    typedef enum logic [1:0] {
        ev_addr   = 2'b00,
        ev_rx     = 2'b01,
        ev_tx     = 2'b11,
        ev_tx_end = 2'b10
    } i2csl_event_t;

endpackage

// *** i2csl_slave.sv ***
// slave-side serial port engine, software side on clock_in, bus side on link
`timescale 1ns/1ps
`include "i2csl_defines.svh"
module i2csl_slave (
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    input  wire logic       link_clk_in,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       port_enable_bit_in,
    input  wire logic [3:0] port_mode_field_in,
    input  wire logic [5:1] address_mask_bits_in,
    input  wire logic       stretch_enable_bit_in,
    input  wire logic       clock_release_bit_in,
    input  wire logic       slave_address_wr_in,
    input  wire logic [7:0] slave_address_in,
    input  wire logic       transfer_buffer_wr_in,
    input  wire logic [7:0] transfer_buffer_wr_data_in,
    input  wire logic       transfer_buffer_rd_in,
    input  wire logic       overflow_clear_in,
    input  wire logic       irq_clear_in,
    output logic [7:0]      transfer_buffer_out,
    output logic [7:0]      slave_address_reg_out,
    output logic            buffer_full_flag_out,
    output logic            receive_overflow_flag_out,
    output logic            port_interrupt_flag_out,
    output logic            address_update_flag_out,
    output logic            read_write_out,
    output logic            data_address_out
);

    // software side registers
    logic [7:0]                 buf_q;
    logic [7:0]                 adr_q;
    logic                       bf_q;
    logic                       ov_q;
    logic                       irq_q;
    logic                       ua_q;
    logic                       rw_q;
    logic                       da_q;
    logic                       rel_tog_q;
    logic                       ev_m_q;
    logic                       ev_s_q;
    logic                       ev_d_q;

    // link side registers
    logic                       rst_m_q;
    logic                       rst_s_q;
    logic [`I2CSL_CFG_W-1:0]    cfg_m_q;
    logic [`I2CSL_CFG_W-1:0]    cfg_s_q;
    logic                       rel_m_q;
    logic                       rel_s_q;
    logic                       rel_d_q;
    logic                       scl_m_q;
    logic                       scl_s_q;
    logic                       scl_d_q;
    logic                       sda_m_q;
    logic                       sda_s_q;
    logic                       sda_d_q;
    i2csl_pkg::i2csl_state_t    st_q;
    i2csl_pkg::i2csl_state_t    nx_q;
    logic [3:0]                 cnt_q;
    logic [7:0]                 sh_q;
    logic [7:0]                 tx_sh_q;
    logic                       tx_live_q;
    logic                       ack_q;
    logic                       hold_q;
    logic                       str_q;
    logic                       hi_seen_q;
    logic                       ev_tog_q;
    logic                       ev_pend_q;
    i2csl_pkg::i2csl_event_t    ev_kind_q;
    logic                       ev_load_q;
    logic                       ev_ua_q;
    logic                       ev_rw_q;
    logic [7:0]                 ev_byte_q;

    // software side: event arrival from the link
    wire ev_edge   = ev_s_q ^ ev_d_q;
    wire ev_is_adr = ev_edge & (ev_kind_q == i2csl_pkg::ev_addr);
    wire ev_is_rx  = ev_edge & (ev_kind_q == i2csl_pkg::ev_rx);
    wire ev_is_tx  = ev_edge & (ev_kind_q == i2csl_pkg::ev_tx);
    wire ev_is_end = ev_edge & (ev_kind_q == i2csl_pkg::ev_tx_end);
    wire ev_load   = (ev_is_adr | ev_is_rx) & ev_load_q;
    wire ov_set    = (ev_is_adr | ev_is_rx) & ~ev_load_q & bf_q;
    wire bf_set    = ev_load | transfer_buffer_wr_in;
    wire bf_clr    = transfer_buffer_rd_in | ev_is_tx | ev_is_end;
    wire ua_set    = ev_is_adr & ev_ua_q;
    wire rel_fire  = clock_release_bit_in | (slave_address_wr_in & ua_q);

    wire [7:0] buf_d = transfer_buffer_wr_in ? transfer_buffer_wr_data_in :
                       ev_load ? ev_byte_q : buf_q;

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            buf_q <= `I2CSL_BYTE_RST;
            adr_q <= `I2CSL_BYTE_RST;
        end
        else
        begin
            buf_q <= buf_d;
            if (slave_address_wr_in)
                adr_q <= slave_address_in;
        end
    end

    // flags: a hardware set wins over a same-cycle clear
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            bf_q  <= 1'b0;
            ov_q  <= 1'b0;
            irq_q <= 1'b0;
            ua_q  <= 1'b0;
        end
        else
        begin
            bf_q  <= bf_set | (bf_q & ~bf_clr);
            ov_q  <= ov_set | (ov_q & ~overflow_clear_in);
            irq_q <= ev_edge | (irq_q & ~irq_clear_in);
            ua_q  <= ua_set | (ua_q & ~slave_address_wr_in);
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            rw_q <= 1'b0;
            da_q <= 1'b0;
        end
        else if (ev_is_end)
        begin
            rw_q <= 1'b0;
            da_q <= 1'b0;
        end
        else if (ev_load & ev_is_adr)
        begin
            rw_q <= ev_rw_q;
            da_q <= 1'b0;
        end
        else if (ev_load | ev_is_tx)
            da_q <= 1'b1;
    end

    // event toggle from link; release toggle to link
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            ev_m_q    <= 1'b0;
            ev_s_q    <= 1'b0;
            ev_d_q    <= 1'b0;
            rel_tog_q <= 1'b0;
        end
        else
        begin
            ev_m_q    <= ev_tog_q;
            ev_s_q    <= ev_m_q;
            ev_d_q    <= ev_s_q;
            rel_tog_q <= rel_tog_q ^ rel_fire;
        end
    end

    assign transfer_buffer_out       = buf_q;
    assign slave_address_reg_out     = adr_q;
    assign buffer_full_flag_out      = bf_q;
    assign receive_overflow_flag_out = ov_q;
    assign port_interrupt_flag_out   = irq_q;
    assign address_update_flag_out   = ua_q;
    assign read_write_out            = rw_q;
    assign data_address_out          = da_q;

    // config levels; address and buffer must be quiet while they cross,
    // which holds since software writes them with the clock stretched
    wire [`I2CSL_CFG_W-1:0] cfg = {port_enable_bit_in, port_mode_field_in,
                                   address_mask_bits_in,
                                   stretch_enable_bit_in, bf_q, ov_q,
                                   adr_q, buf_q};

    // link side: reset, config, release and pin synchronisers
    always_ff @(posedge link_clk_in)
    begin
        rst_m_q <= sys_rst_in;
        rst_s_q <= rst_m_q;
        cfg_m_q <= cfg;
        cfg_s_q <= cfg_m_q;
        rel_m_q <= rel_tog_q;
        rel_s_q <= rel_m_q;
        rel_d_q <= rel_s_q;
        scl_m_q <= scl_in;
        scl_s_q <= scl_m_q;
        scl_d_q <= scl_s_q;
        sda_m_q <= sda_in;
        sda_s_q <= sda_m_q;
        sda_d_q <= sda_s_q;
    end

    wire       en_l   = cfg_s_q[28];
    wire [3:0] mode_l = cfg_s_q[27:24];
    wire [5:1] mask_l = cfg_s_q[23:19];
    wire       sen_l  = cfg_s_q[18];
    wire       bf_l   = cfg_s_q[17];
    wire       ov_l   = cfg_s_q[16];
    wire [7:0] adr_l  = cfg_s_q[15:8];
    wire [7:0] buf_l  = cfg_s_q[7:0];

    // master codes are accepted but idle here; only slave codes run
    wire slave_mode = (mode_l == `I2CSL_MODE_SLV7)
                    | (mode_l == `I2CSL_MODE_SLV10)
                    | (mode_l == `I2CSL_MODE_SLV7_SP)
                    | (mode_l == `I2CSL_MODE_SLV10_SP);
    wire bus_mode   = slave_mode | (mode_l == `I2CSL_MODE_MASTER)
                    | (mode_l == `I2CSL_MODE_FW_MASTER);
    wire active     = en_l & slave_mode;
    wire ten        = mode_l[`I2CSL_MODE_TEN_BIT];

    wire scl_rise   = scl_s_q & ~scl_d_q;
    wire scl_fall   = ~scl_s_q & scl_d_q;
    wire start_det  = scl_s_q & scl_d_q & ~sda_s_q & sda_d_q;
    wire stop_det   = scl_s_q & scl_d_q & sda_s_q & ~sda_d_q;
    wire rel_edge   = rel_s_q ^ rel_d_q;

    wire in_idle    = st_q == i2csl_pkg::st_idle;
    wire in_addr    = st_q == i2csl_pkg::st_addr;
    wire in_addr2   = st_q == i2csl_pkg::st_addr2;
    wire in_rx      = st_q == i2csl_pkg::st_rx;
    wire in_tx      = st_q == i2csl_pkg::st_tx;
    wire shifting   = in_addr | in_addr2 | in_rx;
    wire fall8      = scl_fall & (cnt_q == `I2CSL_LAST_DATA_FALL);
    wire fall9      = scl_fall & (cnt_q == `I2CSL_BITS_PER_BYTE);
    wire rise9      = scl_rise & (cnt_q == `I2CSL_BITS_PER_BYTE);

    // address decode at the eighth falling edge
    wire       rw_bit = sh_q[0];
    wire [7:1] m7     = {2'b00, mask_l};
    wire [7:0] m10    = {2'b00, mask_l[5:2], mask_l[1], mask_l[1]};
    wire hit7   = ((sh_q[7:1] ^ adr_l[7:1]) & ~m7) == 7'h00;
    wire hit_hi = (sh_q[7:3] == `I2CSL_TEN_HDR)
                & (sh_q[7:1] == adr_l[7:1]);
    wire hit_lo = ((sh_q ^ adr_l) & ~m10) == 8'h00;
    wire room   = ~bf_l & ~ov_l;

    wire acc7   = in_addr & ~ten & hit7;
    wire acc_hw = in_addr & ten & hit_hi & ~rw_bit;
    wire acc_hr = in_addr & ten & hit_hi & rw_bit & hi_seen_q;
    wire acc_lo = in_addr2 & hit_lo;
    wire d_acc  = acc7 | acc_hw | acc_hr | acc_lo | in_rx;
    wire d_ua   = acc_hw | acc_lo;
    wire d_read = (acc7 | acc_hr) & rw_bit;
    wire d_str  = d_read | d_ua | (in_rx & sen_l & room);

    i2csl_pkg::i2csl_state_t d_nx;
    assign d_nx = ~d_acc ? i2csl_pkg::st_idle :
                  d_read ? i2csl_pkg::st_tx :
                  acc_hw ? i2csl_pkg::st_addr2 : i2csl_pkg::st_rx;

    i2csl_pkg::i2csl_event_t d_kind;
    assign d_kind = in_rx ? i2csl_pkg::ev_rx : i2csl_pkg::ev_addr;

    // bit engine
    always_ff @(posedge link_clk_in)
    begin
        if (rst_s_q | ~active)
        begin
            st_q      <= i2csl_pkg::st_idle;
            cnt_q     <= 4'h0;
            ack_q     <= 1'b0;
            hold_q    <= 1'b0;
            tx_live_q <= 1'b0;
            hi_seen_q <= 1'b0;
        end
        else if (start_det)
        begin
            st_q      <= i2csl_pkg::st_addr;
            cnt_q     <= 4'hf; // the start's own scl fall wraps it to zero
            ack_q     <= 1'b0;
            hold_q    <= 1'b0;
            tx_live_q <= 1'b0;
        end
        else if (stop_det)
        begin
            st_q      <= i2csl_pkg::st_idle;
            ack_q     <= 1'b0;
            hold_q    <= 1'b0;
            tx_live_q <= 1'b0;
            hi_seen_q <= 1'b0;
        end
        else if (fall8 & ~in_idle)
        begin
            cnt_q     <= `I2CSL_BITS_PER_BYTE;
            ack_q     <= ~in_tx & d_acc & room;
            tx_live_q <= 1'b0;
        end
        else if (fall9)
        begin
            cnt_q     <= 4'h0;
            ack_q     <= 1'b0;
            st_q      <= nx_q;
            hold_q    <= str_q;
            hi_seen_q <= hi_seen_q | (in_addr2 & (nx_q == i2csl_pkg::st_rx));
        end
        else if (scl_fall & ~in_idle)
            cnt_q <= cnt_q + 4'h1;
        else if (rel_edge & hold_q)
        begin
            hold_q    <= 1'b0;
            tx_live_q <= in_tx;
        end
    end

    // byte shifting: in on rise, out on fall
    always_ff @(posedge link_clk_in)
    begin
        if (rst_s_q)
        begin
            sh_q    <= `I2CSL_BYTE_RST;
            tx_sh_q <= `I2CSL_BYTE_RST;
        end
        else
        begin
            if (scl_rise & shifting & ~cnt_q[3])
                sh_q <= {sh_q[6:0], sda_s_q};
            if (rel_edge & hold_q & in_tx)
                tx_sh_q <= buf_l;
            else if (scl_fall & in_tx & ~cnt_q[3])
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
    end

    // decision and event payload, then toggle on the ninth fall
    always_ff @(posedge link_clk_in)
    begin
        if (rst_s_q)
        begin
            nx_q      <= i2csl_pkg::st_idle;
            str_q     <= 1'b0;
            ev_pend_q <= 1'b0;
            ev_tog_q  <= 1'b0;
            ev_kind_q <= i2csl_pkg::ev_addr;
            ev_load_q <= 1'b0;
            ev_ua_q   <= 1'b0;
            ev_rw_q   <= 1'b0;
            ev_byte_q <= `I2CSL_BYTE_RST;
        end
        else if (fall8 & shifting & ~start_det & ~stop_det)
        begin
            nx_q      <= d_nx;
            str_q     <= d_acc & d_str;
            ev_pend_q <= d_acc;
            ev_kind_q <= d_kind;
            ev_load_q <= room;
            ev_ua_q   <= d_ua;
            ev_rw_q   <= rw_bit;
            ev_byte_q <= sh_q;
        end
        else if (rise9 & in_tx)
        begin
            nx_q      <= sda_s_q ? i2csl_pkg::st_idle : i2csl_pkg::st_tx;
            str_q     <= ~sda_s_q;
            ev_pend_q <= 1'b1;
            ev_kind_q <= sda_s_q ? i2csl_pkg::ev_tx_end : i2csl_pkg::ev_tx;
            ev_load_q <= 1'b0;
            ev_ua_q   <= 1'b0;
        end
        else if (fall9 & ~start_det & ~stop_det & active)
        begin
            ev_tog_q  <= ev_tog_q ^ ev_pend_q;
            ev_pend_q <= 1'b0;
        end
    end

    // open-drain pins: only ever pull low
    wire drive_tx = in_tx & tx_live_q & ~cnt_q[3] & ~tx_sh_q[7];
    wire pins_own = en_l & bus_mode;
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe_out = pins_own & active & hold_q;
    assign sda_oe_out = pins_own & active & (ack_q | drive_tx);

endmodule // i2csl_slave

// *** i2csl_slave_assertions.sv ***
// concurrent checks on the ports of the slave-side serial port engine
`timescale 1ns/1ps
module i2csl_slave_checker (
    input wire logic       clock_in,
    input wire logic       sys_rst_in,
    input wire logic       port_enable_bit_in,
    input wire logic [3:0] port_mode_field_in,
    input wire logic       scl_out,
    input wire logic       scl_oe_out,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       transfer_buffer_rd_in,
    input wire logic       transfer_buffer_wr_in,
    input wire logic [7:0] transfer_buffer_wr_data_in,
    input wire logic       slave_address_wr_in,
    input wire logic [7:0] slave_address_in,
    input wire logic       overflow_clear_in,
    input wire logic       irq_clear_in,
    input wire logic [7:0] transfer_buffer_out,
    input wire logic [7:0] slave_address_reg_out,
    input wire logic       buffer_full_flag_out,
    input wire logic       receive_overflow_flag_out,
    input wire logic       port_interrupt_flag_out,
    input wire logic       address_update_flag_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // eight cycles leave room for the enable level to cross
    AST_OFF_QUIET: assert property
        (!port_enable_bit_in [*8] |-> !scl_oe_out && !sda_oe_out)
        else $error("pin pulled while port disabled");
    AST_OPEN_DRAIN: assert property
        (scl_oe_out || sda_oe_out |-> !scl_out && !sda_out)
        else $error("pin driven high");
    AST_RD_CLEARS_FULL: assert property
        (transfer_buffer_rd_in |=> !buffer_full_flag_out)
        else $error("full flag kept after buffer read");
    AST_OVF_HOLD: assert property
        (receive_overflow_flag_out && !overflow_clear_in
            |=> receive_overflow_flag_out)
        else $error("overflow flag lost without clear");
    AST_OVF_CLEAR: assert property
        (overflow_clear_in |=> !receive_overflow_flag_out)
        else $error("overflow flag not cleared");
    AST_IRQ_HOLD: assert property
        (port_interrupt_flag_out && !irq_clear_in |=> port_interrupt_flag_out)
        else $error("interrupt flag lost without clear");
    AST_BUF_WRITE: assert property
        (transfer_buffer_wr_in |=> buffer_full_flag_out &&
            transfer_buffer_out == $past(transfer_buffer_wr_data_in))
        else $error("buffer write not taken");
    AST_ADDR_WRITE: assert property
        (slave_address_wr_in |=> !address_update_flag_out &&
            slave_address_reg_out == $past(slave_address_in))
        else $error("address write not taken");
    AST_UPDATE_SET: assert property
        ($rose(address_update_flag_out) |-> port_mode_field_in[0] &&
            buffer_full_flag_out && port_interrupt_flag_out)
        else $error("update flag without its companions");
    AST_OVF_CAUSE: assert property
        ($rose(receive_overflow_flag_out)
            |-> buffer_full_flag_out && port_interrupt_flag_out)
        else $error("overflow without full and interrupt");
    CVR_IRQ: cover property ($rose(port_interrupt_flag_out));
    CVR_UPDATE: cover property ($rose(address_update_flag_out));
    CVR_STRETCH: cover property ($rose(scl_oe_out));
endmodule // i2csl_slave_checker

bind i2csl_slave i2csl_slave_checker i2csl_slave_checker_i (.*);

// *** i2csl_master_model.sv ***
// bus master model driving the serial clock and data wires
`timescale 1ns/1ps
module i2csl_master_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_low_out,
    output logic      sda_low_out
);
    localparam int HALF = 250;
    initial
    begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    // stretch wait capped at 20 us so a stuck slave cannot hang us
    task automatic bit_io(input logic b, output logic s);
        #20 sda_low_out = !b;
        #HALF scl_low_out = 1'b0;
        for (int n = 0; n < 2000 && !scl_in; n++) #10;
        #HALF s = sda_in;
        scl_low_out = 1'b1;
    endtask
    task automatic start;
        #20 sda_low_out = 1'b0;
        #HALF scl_low_out = 1'b0;
        #HALF sda_low_out = 1'b1;
        #HALF scl_low_out = 1'b1;
    endtask
    task automatic stop;
        #20 sda_low_out = 1'b1;
        #HALF scl_low_out = 1'b0;
        #HALF sda_low_out = 1'b0;
        #HALF;
    endtask
    // msb first, ninth bit is the acknowledge slot
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) bit_io(o[k], i[k]);
    endtask
endmodule // i2csl_master_model

// *** i2csl_slave_tb.sv ***
// self-checking bench for the slave-side serial port engine
`timescale 1ns/1ps
module i2csl_slave_tb;
    logic       clock_in, link_clk_in, sys_rst_in, en, str;
    logic [3:0] mode;
    logic [5:1] msk;
    logic [5:0] pl;
    logic [7:0] swd;
    logic [8:0] r;
    wire        scl_oe, sda_oe, m_scl, m_sda, full, ovf, irq, upd, rw, da;
    wire  [7:0] buf_q, adr_q;
    wire        scl = !(scl_oe || m_scl);
    wire        sda = !(sda_oe || m_sda);
    int         err_count = 0, num_checks = 0, cyc = 0;
    localparam logic [15:0] TAB [7] = '{16'h06a0, 16'h8fa0, 16'h88a0,
        16'h8ba0, 16'h83a0, 16'hcea0, 16'hc6a0};
    i2csl_slave i2csl_slave_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .link_clk_in(link_clk_in), .scl_in(scl), .scl_out(),
        .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
        .port_enable_bit_in(en), .port_mode_field_in(mode),
        .address_mask_bits_in(msk), .stretch_enable_bit_in(str),
        .clock_release_bit_in(pl[0]), .slave_address_wr_in(pl[1]),
        .slave_address_in(swd), .transfer_buffer_wr_in(pl[3]),
        .transfer_buffer_wr_data_in(swd), .transfer_buffer_rd_in(pl[2]),
        .overflow_clear_in(pl[5]), .irq_clear_in(pl[4]),
        .transfer_buffer_out(buf_q), .slave_address_reg_out(adr_q),
        .buffer_full_flag_out(full), .receive_overflow_flag_out(ovf),
        .port_interrupt_flag_out(irq), .address_update_flag_out(upd),
        .read_write_out(rw), .data_address_out(da));
    i2csl_master_model m (.scl_in(scl), .sda_in(sda), .scl_low_out(m_scl),
        .sda_low_out(m_sda));
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = !clock_in;
    end
    initial
    begin
        link_clk_in = 1'b0;
        #1.7;
        forever #3 link_clk_in = !link_clk_in;
    end
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle software pulse: 0 release, 1 addr, 2 read, 3 buf, 4 irq
    task automatic sw(input int k, input logic [7:0] d);
        @(negedge clock_in);
        pl[k] = 1'b1;
        swd = d;
        @(negedge clock_in);
        pl = '0;
    endtask
    // bus events need a few cycles to cross into the flags
    task automatic settle;
        repeat (10) @(negedge clock_in);
    endtask
    task automatic serve;
        sw(2, 8'h00);
        sw(4, 8'h00);
    endtask
    task automatic try(input logic [7:0] b, input logic a);
        m.start();
        m.xfer({b, 1'b1}, r);
        m.stop();
        settle();
        chk({!r[0], irq}, {a, a});
        if (a) chk({full, rw, buf_q}, {2'b10, b});
        serve();
    endtask
    task automatic t_modes;
        sw(1, 8'ha0);
        foreach (TAB[i])
        begin
            en = TAB[i][15];
            mode = TAB[i][11:8];
            settle();
            try(TAB[i][7:0], TAB[i][14]);
        end
    endtask
    task automatic t_ovf;
        m.start();
        m.xfer(9'h141, r);
        m.xfer(9'h067, r);
        settle();
        chk({!r[0], ovf, irq, full, buf_q}, {4'h7, 8'ha0});
        sw(2, 8'h00);
        chk({full, ovf}, 2'b01);
        m.stop();
        sw(4, 8'h00);
        m.start();
        m.xfer(9'h141, r);
        m.stop();
        settle();
        chk({!r[0], irq, full}, 3'b010);
        sw(5, 8'h00);
        sw(4, 8'h00);
        chk({ovf, irq}, 2'b00);
    endtask
    task automatic t_mask;
        msk = 5'b00111;
        try(8'hae, 1'b1);
        try(8'ha6, 1'b1);
        try(8'hb0, 1'b0);
        msk = '0;
    endtask
    task automatic t_stretch;
        str = 1'b1;
        m.start();
        m.xfer(9'h141, r);
        settle();
        serve();
        m.xfer(9'h079, r);
        repeat (30) @(negedge clock_in);
        chk({!r[0], scl_oe, da, buf_q}, {3'b111, 8'h3c});
        sw(0, 8'h00);
        settle();
        chk(scl_oe, 1'b0);
        serve();
        m.stop();
        @(negedge clock_in);
        str = 1'b0;
    endtask
    task automatic t_read;
        m.start();
        m.xfer(9'h143, r);
        settle();
        chk({!r[0], rw, scl_oe, buf_q}, {3'b111, 8'ha1});
        serve();
        sw(3, 8'h5a);
        sw(0, 8'h00);
        m.xfer(9'h1fe, r);
        settle();
        chk({scl_oe, irq, r[8:1]}, {2'b11, 8'h5a});
        serve();
        sw(3, 8'hc3);
        sw(0, 8'h00);
        m.xfer(9'h1ff, r);
        settle();
        chk({scl_oe, rw, irq, r[8:1]}, {3'b001, 8'hc3});
        serve();
        m.stop();
    endtask
    task automatic t_ten;
        @(negedge clock_in);
        mode = 4'h7;
        sw(1, 8'hf2);
        settle();
        m.start();
        m.xfer(9'h1e5, r);
        settle();
        chk({!r[0], upd, full, scl_oe}, 4'hf);
        sw(1, 8'h34);
        serve();
        chk({upd, scl_oe, adr_q}, {2'b00, 8'h34});
        m.xfer(9'h069, r);
        settle();
        chk({!r[0], upd, buf_q}, {2'b11, 8'h34});
        sw(1, 8'hf2);
        serve();
        m.start();
        m.xfer(9'h1e7, r);
        settle();
        chk({!r[0], upd, irq, rw, buf_q}, {4'hb, 8'hf3});
        serve();
        sw(3, 8'h96);
        sw(0, 8'h00);
        m.xfer(9'h1ff, r);
        settle();
        chk(r[8:1], 8'h96);
        serve();
        m.stop();
    endtask
    initial
    begin
        sys_rst_in = 1'b1;
        en = 1'b1;
        str = 1'b0;
        mode = 4'h6;
        msk = '0;
        pl = '0;
        swd = 8'h00;
        repeat (16) @(negedge clock_in);
        sys_rst_in = 1'b0;
        chk({full, ovf, irq, upd, scl_oe, sda_oe, buf_q}, 12'h000);
        t_modes();
        t_ovf();
        t_mask();
        t_stretch();
        t_read();
        t_ten();
        report_and_stop();
    end
endmodule // i2csl_slave_tb
